// ===== rtl/band_regs_pkg.sv
// band_regs_pkg: addresses, field layouts and reset values for the banked
// gain-control and synthesizer loop register block.
// assumes an 8-bit register port with 7-bit addresses.
package band_regs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int NUM_BANKS = 2;
  localparam int NUM_REGS = 5;

  // ----------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_OP_MODE      = 7'h01;
  localparam logic [6:0] ADDR_BANK_FIRST   = 7'h61;
  localparam logic [6:0] ADDR_BANK_LAST    = 7'h73;
  localparam logic [6:0] ADDR_FLOOR_REF    = 7'h61;
  localparam logic [6:0] ADDR_THRESH_ONE   = 7'h62;
  localparam logic [6:0] ADDR_THRESH_TWO3  = 7'h63;
  localparam logic [6:0] ADDR_THRESH_FOUR5 = 7'h64;
  localparam logic [6:0] ADDR_SYNTH_LOOP   = 7'h70;

  // register slot indices within one bank
  localparam int SLOT_FLOOR = 0;
  localparam int SLOT_TH1   = 1;
  localparam int SLOT_TH23  = 2;
  localparam int SLOT_TH45  = 3;
  localparam int SLOT_SYNTH = 4;

  // bank indices
  localparam int BANK_HIGH = 0;
  localparam int BANK_LOW  = 1;

  // ----------------------------------------------------------------
  // operating mode register fields
  // ----------------------------------------------------------------
  localparam int OPMODE_BAND_BIT = 3;
  localparam logic [7:0] OPMODE_RESET = 8'h09;
  localparam logic [7:0] OPMODE_WMASK = 8'h0f;

  // ----------------------------------------------------------------
  // writable masks (unused bits read zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_FLOOR = 8'h3f;
  localparam logic [7:0] MASK_TH1   = 8'h1f;
  localparam logic [7:0] MASK_FULL  = 8'hff;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FLOOR_LOW  = 8'h19;
  localparam logic [7:0] RST_FLOOR_HIGH = 8'h1c;
  localparam logic [7:0] RST_TH1_LOW    = 8'h0c;
  localparam logic [7:0] RST_TH1_HIGH   = 8'h0e;
  localparam logic [3:0] RST_TH2_LOW    = 4'h4;
  localparam logic [3:0] RST_TH2_HIGH   = 4'h5;
  localparam logic [3:0] RST_TH3        = 4'hb;
  localparam logic [3:0] RST_TH4        = 4'hc;
  localparam logic [3:0] RST_TH5        = 4'hc;
  localparam logic [1:0] RST_LOOP_BW    = 2'h3;
  localparam logic [5:0] RST_LOOP_RSVD  = 6'h10;

  // synthesizer loop bandwidth codes
  typedef enum logic [1:0] {
    LOOP_BW_75K  = 2'b00,
    LOOP_BW_150K = 2'b01,
    LOOP_BW_225K = 2'b10,
    LOOP_BW_300K = 2'b11
  } loop_bw_t;

endpackage

// ===== rtl/bank_decode.sv
// bank_decode: maps a register address to a slot within one bank.
// assumes addresses come straight from the register port.
`timescale 1ns/1ns
`default_nettype none
module bank_decode
  import band_regs_pkg::*;
(
  input  wire logic [6:0] addr,
  output logic            hit,
  output logic [2:0]      slot
);

  always_comb
  begin
    hit  = 1'b1;
    slot = 3'h0;
    case (addr)
      ADDR_FLOOR_REF:    slot = 3'(SLOT_FLOOR);
      ADDR_THRESH_ONE:   slot = 3'(SLOT_TH1);
      ADDR_THRESH_TWO3:  slot = 3'(SLOT_TH23);
      ADDR_THRESH_FOUR5: slot = 3'(SLOT_TH45);
      ADDR_SYNTH_LOOP:   slot = 3'(SLOT_SYNTH);
      default:           hit  = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ===== rtl/bank_copy.sv
// bank_copy: one band's copy of the five banked registers.
// assumes the parent gates the write strobe with the band select.
`timescale 1ns/1ns
`default_nettype none
module bank_copy
  import band_regs_pkg::*;
#(
  parameter logic [7:0] RST_FLOOR = 8'h00,
  parameter logic [7:0] RST_TH1   = 8'h00,
  parameter logic [3:0] RST_TH2   = 4'h0
)
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       wrEn,
  input  wire logic [2:0] slot,
  input  wire logic [7:0] wrData,
  output logic [7:0]      floorRef,
  output logic [7:0]      threshOne,
  output logic [7:0]      threshTwoThree,
  output logic [7:0]      threshFourFive,
  output logic [7:0]      synthLoop
);

  // unused high bits are held at zero by masking writes to the floor and first threshold
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      floorRef       <= RST_FLOOR;
      threshOne      <= RST_TH1;
      threshTwoThree <= {RST_TH2, RST_TH3};
      threshFourFive <= {RST_TH4, RST_TH5};
      synthLoop      <= {RST_LOOP_BW, RST_LOOP_RSVD};
    end
    else if (wrEn)
    begin
      case (slot)
        3'(SLOT_FLOOR): floorRef       <= wrData & MASK_FLOOR;
        3'(SLOT_TH1):   threshOne      <= wrData & MASK_TH1;
        3'(SLOT_TH23):  threshTwoThree <= wrData;
        3'(SLOT_TH45):  threshFourFive <= wrData;
        3'(SLOT_SYNTH): synthLoop      <= wrData;
        default:        floorRef       <= floorRef;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== rtl/band_banked_regs.sv
// band_banked_regs: dual-bank gain-control and synthesizer loop registers.
// assumes an 8-bit register port; read data appear the cycle after the
// read strobe and only then.
//
// Summary of operation
// - two copies of every register 0x61..0x73: lower band and upper band
// - accesses to the banked range go to the copy chosen by mode bit 3
// - toggling band select leaves both copies' contents untouched
// - band select resets to one, so the lower band copy is default
// - floor reference bits 5-0 at 0x61, reset 0x19 low, 0x1c high
// - first threshold bits 4-0 at 0x62, reset 0x0c low, 0x0e high
// - second threshold bits 7-4 at 0x63, reset 0x04 low, 0x05 high
// - third threshold bits 3-0 at 0x63, reset 0x0b in both copies
// - fourth and fifth thresholds at 0x64, reset 0x0c in both copies
// - loop bandwidth bits 7-6 at 0x70, four codes, reset 0x03
// - band select zero picks upper copy, one picks lower copy
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module band_banked_regs
  import band_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic [7:0]      rdData,
  output logic            bandSelectLow,
  output logic [5:0]      gainFloorReference,
  output logic [4:0]      gainThresholdFirst,
  output logic [3:0]      gainThresholdSecond,
  output logic [3:0]      gainThresholdThird,
  output logic [3:0]      gainThresholdFourth,
  output logic [3:0]      gainThresholdFifth,
  output logic [1:0]      synthLoopBandwidth
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic       bankHit;
  logic [2:0] slot;
  logic [7:0] opMode;

  bank_decode u_decode (
    .addr (addr),
    .hit  (bankHit),
    .slot (slot)
  );

  // ----------------------------------------------------------------
  // operating mode register (only the band select steers this block)
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      opMode <= OPMODE_RESET;
    else if (wrStrobe && addr == ADDR_OP_MODE)
      opMode <= wrData & OPMODE_WMASK;
  end

  // ----------------------------------------------------------------
  // the two bank copies
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FLOOR_B [NUM_BANKS] = '{RST_FLOOR_HIGH, RST_FLOOR_LOW};
  localparam logic [7:0] RST_TH1_B   [NUM_BANKS] = '{RST_TH1_HIGH, RST_TH1_LOW};
  localparam logic [3:0] RST_TH2_B   [NUM_BANKS] = '{RST_TH2_HIGH, RST_TH2_LOW};

  logic       bandSel;
  logic [7:0] bankRegs [NUM_BANKS][NUM_REGS];

  assign bandSel = opMode[OPMODE_BAND_BIT];

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++)
    begin : g_bank
      logic bankWr;
      // only the selected copy sees the write; the other keeps its state
      assign bankWr = wrStrobe && bankHit && (bandSel == 1'(b));
      bank_copy #(
        .RST_FLOOR (RST_FLOOR_B[b]),
        .RST_TH1   (RST_TH1_B[b]),
        .RST_TH2   (RST_TH2_B[b])
      ) u_copy (
        .clk            (clk),
        .srst           (srst),
        .wrEn           (bankWr),
        .slot           (slot),
        .wrData         (wrData),
        .floorRef       (bankRegs[b][SLOT_FLOOR]),
        .threshOne      (bankRegs[b][SLOT_TH1]),
        .threshTwoThree (bankRegs[b][SLOT_TH23]),
        .threshFourFive (bankRegs[b][SLOT_TH45]),
        .synthLoop      (bankRegs[b][SLOT_SYNTH])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdData;

  always_comb
  begin
    next_rdData = 8'h00;
    if (addr == ADDR_OP_MODE)
      next_rdData = opMode;
    else if (bankHit)
      next_rdData = bankRegs[bandSel][slot];
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (srst)
      rdData <= 8'h00;
    else if (rdStrobe)
      rdData <= next_rdData;
    else
      rdData <= 8'h00;
  end

  // ----------------------------------------------------------------
  // active-band field outputs to the receiver and synthesizer
  // ----------------------------------------------------------------
  // registered so the outputs follow the selected band one cycle late
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bandSelectLow       <= OPMODE_RESET[OPMODE_BAND_BIT];
      gainFloorReference  <= RST_FLOOR_LOW[5:0];
      gainThresholdFirst  <= RST_TH1_LOW[4:0];
      gainThresholdSecond <= RST_TH2_LOW;
      gainThresholdThird  <= RST_TH3;
      gainThresholdFourth <= RST_TH4;
      gainThresholdFifth  <= RST_TH5;
      synthLoopBandwidth  <= RST_LOOP_BW;
    end
    else
    begin
      bandSelectLow       <= bandSel;
      gainFloorReference  <= bankRegs[bandSel][SLOT_FLOOR][5:0];
      gainThresholdFirst  <= bankRegs[bandSel][SLOT_TH1][4:0];
      gainThresholdSecond <= bankRegs[bandSel][SLOT_TH23][7:4];
      gainThresholdThird  <= bankRegs[bandSel][SLOT_TH23][3:0];
      gainThresholdFourth <= bankRegs[bandSel][SLOT_TH45][7:4];
      gainThresholdFifth  <= bankRegs[bandSel][SLOT_TH45][3:0];
      synthLoopBandwidth  <= bankRegs[bandSel][SLOT_SYNTH][7:6];
    end
  end

endmodule
`default_nettype wire

// ===== test/band_banked_regs_chk.sv
// band_banked_regs_chk: port-level properties of the banked register block.
// assumes it is bound to band_banked_regs and sees one clock domain.
`timescale 1ns/1ns
`default_nettype none
module band_banked_regs_chk
  import band_regs_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [6:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStrobe,
  input wire logic       rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic       bandSelectLow,
  input wire logic [5:0] gainFloorReference,
  input wire logic [1:0] synthLoopBandwidth
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_rd_idle;
    !rdStrobe |=> rdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_mode_hi;
    rdStrobe && addr == ADDR_OP_MODE |=> rdData[7:4] == 4'h0;
  endproperty
  a_mode_hi: assert property (p_mode_hi) else $error("mode high bits set");
  property p_floor_hi;
    rdStrobe && addr == 7'h61 |=> rdData[7:6] == 2'h0;
  endproperty
  a_floor_hi: assert property (p_floor_hi) else $error("floor unused bits");
  property p_th1_hi;
    rdStrobe && addr == 7'h62 |=> rdData[7:5] == 3'h0;
  endproperty
  a_th1_hi: assert property (p_th1_hi) else $error("threshold unused bits");
  property p_unmapped;
    rdStrobe && addr inside {[7'h65:7'h6f], [7'h71:7'h73]} |=> rdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_reset;
    $fell(srst) |-> bandSelectLow && synthLoopBandwidth == 2'h3 && gainFloorReference == 6'h19;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  // field outputs may lag a write by two cycles, so only quiet stretches count
  property p_hold;
    !wrStrobe [*3] |=> $stable(gainFloorReference);
  endproperty
  a_hold: assert property (p_hold) else $error("field moved without write");
  property p_wr_rd;
    wrStrobe && addr == 7'h63 ##1 rdStrobe && addr == 7'h63 |=> rdData == $past(wrData, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback mismatch");
endmodule
`default_nettype wire

// ===== test/band_banked_regs_tb_top.sv
// band_banked_regs_tb_top: self-checking bench with a behavioural model.
// assumes read data one cycle after the strobe, 20 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module band_banked_regs_tb_top;
  import band_regs_pkg::*;
  // ----------------------------------------------------------------
  // signals and model
  // ----------------------------------------------------------------
  localparam logic [6:0] POOL [10] = '{7'h01, 7'h61, 7'h62, 7'h63, 7'h64, 7'h70,
                                       7'h65, 7'h6f, 7'h73, 7'h7f};
  localparam logic [6:0] MAP [5] = '{7'h61, 7'h62, 7'h63, 7'h64, 7'h70};
  localparam logic [7:0] WMASK [5] = '{8'h3f, 8'h1f, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] RSTV [2][5] = '{'{8'h1c, 8'h0e, 8'h5b, 8'hcc, 8'hd0},
                                         '{8'h19, 8'h0c, 8'h4b, 8'hcc, 8'hd0}};
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [7:0] wrData = 8'h00;
  logic       wrStrobe = 1'b0;
  logic       rdStrobe = 1'b0;
  logic       rdPend = 1'b0;
  logic [7:0] rdData;
  logic       bandSelectLow;
  logic [5:0] gainFloorReference;
  logic [4:0] gainThresholdFirst;
  logic [3:0] gainThresholdSecond, gainThresholdThird;
  logic [3:0] gainThresholdFourth, gainThresholdFifth;
  logic [1:0] synthLoopBandwidth;
  logic [7:0] bank [2][5];
  logic [7:0] opMode;
  logic [7:0] expQ [$];
  int         failures = 0;
  int         n_compared = 0;
  int         cyc = 0;

  always #25 clk = ~clk;

  band_banked_regs u_band_banked_regs (
    .clk(clk), .srst(srst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .bandSelectLow(bandSelectLow),
    .gainFloorReference(gainFloorReference), .gainThresholdFirst(gainThresholdFirst),
    .gainThresholdSecond(gainThresholdSecond), .gainThresholdThird(gainThresholdThird),
    .gainThresholdFourth(gainThresholdFourth), .gainThresholdFifth(gainThresholdFifth),
    .synthLoopBandwidth(synthLoopBandwidth));

  function automatic logic [7:0] model(logic [6:0] a);
    model = (a == ADDR_OP_MODE) ? (opMode & 8'h0f) : 8'h00;
    foreach (MAP[i])
      if (MAP[i] == a)
        model = bank[opMode[3]][i];
  endfunction

  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus tasks and monitor
  // ----------------------------------------------------------------
  task automatic wr(logic [6:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    rdStrobe <= 1'b0;
    if (a == ADDR_OP_MODE)
      opMode = d & 8'h0f;
    foreach (MAP[i])
      if (MAP[i] == a)
        bank[opMode[3]][i] = d & WMASK[i];
  endtask

  task automatic rd(logic [6:0] a);
    @(posedge clk);
    addr <= a;
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b1;
    expQ.push_back(model(a));
  endtask

  task automatic idle(int n);
    repeat (n)
    begin
      @(posedge clk);
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
    end
  endtask

  // reads every pooled address, mapped or not, then lets the last answer land
  task automatic readAll();
    foreach (POOL[i])
      rd(POOL[i]);
    idle(2);
  endtask

  task automatic chkFields();
    logic [7:0] b [5];
    idle(3);
    @(negedge clk);
    b = bank[opMode[3]];
    check({7'h0, bandSelectLow}, {7'h0, opMode[3]});
    check({2'h0, gainFloorReference}, {2'h0, b[0][5:0]});
    check({3'h0, gainThresholdFirst}, {3'h0, b[1][4:0]});
    check({gainThresholdSecond, gainThresholdThird}, b[2]);
    check({gainThresholdFourth, gainThresholdFifth}, b[3]);
    check({6'h0, synthLoopBandwidth}, {6'h0, b[4][7:6]});
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rdPend)
      check(rdData, expQ.pop_front());
    rdPend <= rdStrobe & ~srst;
    if (cyc == 5000)
    begin
      failures++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [6:0] a;
    logic [7:0] d;
    d = 8'($urandom(32'hee15c22f));
    opMode = 8'h09;
    bank = RSTV;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    readAll();
    chkFields();
    $display("test reset values done");
    wr(ADDR_OP_MODE, 8'h01);
    readAll();
    chkFields();
    $display("test upper band done");
    for (int c = 0; c < 4; c++)
    begin
      wr(7'h70, {c[1:0], 6'h10});
      rd(7'h70);
    end
    wr(7'h61, 8'hff);
    wr(7'h62, 8'hff);
    wr(7'h63, 8'ha5);
    rd(7'h63);
    rd(7'h61);
    rd(7'h62);
    chkFields();
    $display("test field writes done");
    repeat (80)
    begin
      a = POOL[$urandom_range(0, 9)];
      d = 8'($urandom);
      if (a == 7'h70)
        d[5:0] = 6'h10;
      if ($urandom_range(0, 1) == 1)
        wr(a, d);
      else
        rd(a);
    end
    readAll();
    chkFields();
    wr(ADDR_OP_MODE, opMode ^ 8'h08);
    readAll();
    chkFields();
    $display("test random traffic done");
    @(posedge clk);
    srst <= 1'b1;
    idle(5);
    opMode = 8'h09;
    bank = RSTV;
    srst <= 1'b0;
    readAll();
    chkFields();
    $display("test second reset done");
    final_report();
  end
endmodule

bind band_banked_regs band_banked_regs_chk u_band_banked_regs_chk (
  .clk(clk), .srst(srst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
  .rdStrobe(rdStrobe), .rdData(rdData), .bandSelectLow(bandSelectLow),
  .gainFloorReference(gainFloorReference), .synthLoopBandwidth(synthLoopBandwidth));
`default_nettype wire
